// ==== rvic_chain.sv ====
`timescale 1ns/100ps
module rvic_chain
	import rvic_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	rvic_chain_if.ctl ch
);
	logic in_service_r;
	logic in_service_nxt;
	// A request may start only while the chain above lets us through.
	assign ch.req_ok = ch.chain_in;
	// Service holds until end-of-service; a new request in that cycle wins.
	assign in_service_nxt = (ch.pending && ch.chain_in) ? 1'b1 :
		(ch.service_done ? 1'b0 : in_service_r);
	assign ch.chain_out = ch.chain_in && !in_service_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_service_r <= 1'b0;
		end else begin
			in_service_r <= in_service_nxt;
		end
	end
	held_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(in_service_r && !ch.service_done) |=> !ch.chain_out)
		else $error("chain out rose during service");
endmodule : rvic_chain

// ==== rvic_chain_if.sv ====
`timescale 1ns/100ps
interface rvic_chain_if;
	logic chain_in;
	logic pending;
	logic service_done;
	logic req_ok;
	logic chain_out;
	modport ctl (input chain_in, input pending, input service_done, output req_ok,
		output chain_out);
	modport top (output chain_in, output pending, output service_done, input req_ok,
		input chain_out);
endinterface : rvic_chain_if

// ==== rvic_host_model.sv ====
`timescale 1ns/100ps
module rvic_host_model (
	input wire logic core_clk,
	input wire logic [7:0] bus,
	input wire logic oe,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic ack_n,
	output logic [1:0] sel,
	output logic [7:0] wd
);
	initial begin
		{cs_n, rd_n, wr_n, ack_n} = 4'hf;
		sel = 2'h0;
		wd = 8'h00;
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		{cs_n, wr_n, sel, wd} = {2'b00, a, d};
		@(posedge core_clk) #1;
		// Released write data shows the inverse so a stale byte cannot pass.
		{cs_n, wr_n, wd} = {2'b11, ~d};
	endtask : wr
	task automatic rd(input logic k, input logic c, input logic [1:0] a,
		output logic [7:0] d, output logic v);
		@(posedge core_clk) #1;
		ack_n = k;
		if (!k) @(posedge core_clk) #1;
		{cs_n, rd_n, sel} = {c, 1'b0, a};
		v = 1'b0;
		for (int i = 0; i < 4 && !v; i++) begin
			@(posedge core_clk) #1;
			v = oe;
			d = bus;
		end
		{cs_n, rd_n, ack_n} = 3'b111;
	endtask : rd
endmodule : rvic_host_model

// ==== rvic_pkg.sv ====
// Summary of operation
// - Master reset clears channel status, interrupt status, mask, output value and config.
// - Master reset loads the interrupt vector register with 0x0f.
// - Master reset halts the counter/timer until software restarts it.
// - Master reset drives all eight general outputs high.
// - Master reset idles both channels; both transmit lines held marking high.
// - Data lines float whenever chip select is high, except during acknowledge in chained mode.
// - Host transfers happen only while chip select is low.
// - Inputs 2, 6, 5, 4 can serve as timer, rx B, tx B, rx A clocks.
// - In chained mode, during acknowledge the device drives the interrupt vector onto the data lines.
// - In chained mode, chain enable out follows chain enable in low, back high when it rises unless in service; plain mode holds it high.
// - In chained mode, after raising a request, chain enable out stays low until end-of-service.
// - In chained mode, requests are raised only while chain enable in is high; plain mode ignores it.
// - Request output asserted while any unmasked condition exists, negated when all clear; chained mode also holds it off while chain enable in is low.
// - In chained mode, data lines are driven during acknowledge despite chip select high.
package rvic_pkg;
	localparam logic [7:0] RVIC_VEC_RST = 8'h0f;
	localparam logic [7:0] RVIC_ZERO_RST = 8'h00;
	localparam logic [7:0] RVIC_OUT_RST = 8'hff;
	localparam logic RVIC_MARK = 1'b1;
	localparam int RVIC_CLK_TIN = 2;
	localparam int RVIC_CLK_RXB = 6;
	localparam int RVIC_CLK_TXB = 5;
	localparam int RVIC_CLK_RXA = 4;
	localparam logic [1:0] RVIC_REG_VEC = 2'h0;
	localparam logic [1:0] RVIC_REG_MASK = 2'h1;
	localparam logic [1:0] RVIC_REG_STAT = 2'h2;
	localparam logic [1:0] RVIC_REG_OUT = 2'h3;
endpackage : rvic_pkg

// ==== rvic_top.sv ====
`timescale 1ns/100ps
module rvic_top
	import rvic_pkg::*;
#(
	parameter int DW = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic master_reset,
	input wire logic chained_mode,
	input wire logic chip_sel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [1:0] reg_sel,
	input wire logic [DW-1:0] host_data_lines_i,
	output logic [DW-1:0] host_data_lines_o,
	output logic host_data_lines_oe,
	input wire logic request_n_a_ack_n,
	input wire logic chain_enable_in,
	output logic chain_enable_out,
	input wire logic end_of_service,
	input wire logic [7:0] event_set,
	input wire logic [6:0] general_inputs,
	input wire logic [3:0] alt_clock_sel,
	input wire logic timer_restart,
	input wire logic [DW-1:0] channel_status_set,
	output logic request_n_a_o,
	output logic request_n_a_oe,
	output logic [7:0] general_outputs,
	output logic serial_tx_a,
	output logic serial_tx_b,
	output logic timer_running,
	output logic timer_ext_clock,
	output logic rx_clock_b,
	output logic tx_clock_b,
	output logic rx_clock_a,
	output logic [DW-1:0] channel_status
);
	logic [DW-1:0] interrupt_vector_reg_r;
	logic [7:0] interrupt_mask_reg_r;
	logic [7:0] interrupt_status_reg_r;
	logic [7:0] output_port_value_reg_r;
	logic [7:0] output_port_config_reg_r;
	logic [DW-1:0] channel_status_reg_r;
	logic ack_armed_r;
	logic mode_r;
	logic mode_seen_r;
	logic [DW-1:0] rd_data_nxt;
	logic oe_nxt;
	logic [7:0] status_nxt;

	// One decode serves every register write so the select map lives in one place.
	function automatic logic wr_hit(input logic wr, input logic [1:0] sel,
		input logic [1:0] code);
		return wr && (sel == code);
	endfunction : wr_hit

	wire cs_ok = !chip_sel_n;
	wire bus_rd = cs_ok && !rd_n;
	wire bus_wr = cs_ok && !wr_n && rd_n;
	wire hit_vec = wr_hit(bus_wr, reg_sel, RVIC_REG_VEC);
	wire hit_mask = wr_hit(bus_wr, reg_sel, RVIC_REG_MASK);
	wire hit_stat = wr_hit(bus_wr, reg_sel, RVIC_REG_STAT);
	wire hit_out = wr_hit(bus_wr, reg_sel, RVIC_REG_OUT);
	wire ack_cycle = mode_r && ack_armed_r && !rd_n;
	wire [7:0] unmasked = interrupt_status_reg_r & interrupt_mask_reg_r;
	wire any_cond = |unmasked;
	wire req_raise;
	rvic_chain_if ch_if();
	assign ch_if.chain_in = mode_r ? chain_enable_in : 1'b1;
	assign ch_if.pending = any_cond && mode_r;
	assign ch_if.service_done = end_of_service;
	rvic_chain u_rvic_chain (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ch(ch_if)
	);
	assign req_raise = any_cond && ch_if.req_ok;
	// Selected read data; acknowledge takes priority over a plain read.
	always_comb begin
		rd_data_nxt = '0;
		if (ack_cycle) begin
			rd_data_nxt = interrupt_vector_reg_r;
		end else begin
			unique case (reg_sel)
				RVIC_REG_VEC: rd_data_nxt = interrupt_vector_reg_r;
				RVIC_REG_MASK: rd_data_nxt = DW'(interrupt_mask_reg_r);
				RVIC_REG_STAT: rd_data_nxt = DW'(interrupt_status_reg_r);
				RVIC_REG_OUT: rd_data_nxt = DW'(output_port_value_reg_r);
			endcase
		end
	end
	assign oe_nxt = !master_reset && (bus_rd || ack_cycle);
	// Set wins over a write-one-to-clear in the same cycle.
	assign status_nxt = hit_stat ?
		((interrupt_status_reg_r & ~host_data_lines_i[7:0]) | event_set) :
		(interrupt_status_reg_r | event_set);
	// Mode is sampled once after reset release and then held.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_seen_r <= 1'b0;
			mode_r <= 1'b0;
		end else if (!mode_seen_r) begin
			mode_seen_r <= 1'b1;
			mode_r <= chained_mode;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_armed_r <= 1'b0;
		end else if (!request_n_a_ack_n) begin
			ack_armed_r <= 1'b1;
		end else if (rd_n) begin
			ack_armed_r <= 1'b0;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_vector_reg_r <= DW'(RVIC_VEC_RST);
			interrupt_mask_reg_r <= RVIC_ZERO_RST;
			interrupt_status_reg_r <= RVIC_ZERO_RST;
			output_port_value_reg_r <= RVIC_ZERO_RST;
			output_port_config_reg_r <= RVIC_ZERO_RST;
			channel_status_reg_r <= '0;
		end else if (master_reset) begin
			interrupt_vector_reg_r <= DW'(RVIC_VEC_RST);
			interrupt_mask_reg_r <= RVIC_ZERO_RST;
			interrupt_status_reg_r <= RVIC_ZERO_RST;
			output_port_value_reg_r <= RVIC_ZERO_RST;
			output_port_config_reg_r <= RVIC_ZERO_RST;
			channel_status_reg_r <= '0;
		end else begin
			interrupt_status_reg_r <= status_nxt;
			channel_status_reg_r <= channel_status_reg_r | channel_status_set;
			if (hit_vec) begin
				interrupt_vector_reg_r <= host_data_lines_i;
			end
			if (hit_mask) begin
				interrupt_mask_reg_r <= host_data_lines_i[7:0];
			end
			if (hit_out) begin
				output_port_value_reg_r <= host_data_lines_i[7:0];
			end
		end
	end
	// Outputs are registered; value register bits drive the pins inverted, so zero reads high.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_data_lines_o <= '0;
			host_data_lines_oe <= 1'b0;
			request_n_a_o <= 1'b0;
			request_n_a_oe <= 1'b0;
			chain_enable_out <= 1'b1;
			general_outputs <= RVIC_OUT_RST;
			serial_tx_a <= RVIC_MARK;
			serial_tx_b <= RVIC_MARK;
			timer_running <= 1'b0;
			timer_ext_clock <= 1'b0;
			rx_clock_b <= 1'b0;
			tx_clock_b <= 1'b0;
			rx_clock_a <= 1'b0;
			channel_status <= '0;
		end else begin
			host_data_lines_o <= rd_data_nxt;
			host_data_lines_oe <= oe_nxt;
			request_n_a_o <= 1'b0;
			request_n_a_oe <= req_raise && !master_reset;
			chain_enable_out <= mode_r ? ch_if.chain_out : 1'b1;
			general_outputs <= master_reset ? RVIC_OUT_RST : ~output_port_value_reg_r;
			serial_tx_a <= RVIC_MARK;
			serial_tx_b <= RVIC_MARK;
			timer_running <= master_reset ? 1'b0 : (timer_restart ? 1'b1 : timer_running);
			timer_ext_clock <= alt_clock_sel[0] && general_inputs[RVIC_CLK_TIN];
			rx_clock_b <= alt_clock_sel[1] && general_inputs[RVIC_CLK_RXB];
			tx_clock_b <= alt_clock_sel[2] && general_inputs[RVIC_CLK_TXB];
			rx_clock_a <= alt_clock_sel[3] && general_inputs[RVIC_CLK_RXA];
			channel_status <= channel_status_reg_r;
		end
	end
	float_cs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(chip_sel_n && !ack_cycle) |=> !host_data_lines_oe)
		else $error("data driven with chip select high");
	vec_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ack_cycle && !master_reset) |=> host_data_lines_oe &&
		host_data_lines_o == $past(interrupt_vector_reg_r))
		else $error("vector missing in acknowledge");
	reset_vec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset |=> interrupt_vector_reg_r == DW'(RVIC_VEC_RST))
		else $error("vector not reloaded");
	reset_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset |=> interrupt_mask_reg_r == 8'h00 && output_port_config_reg_r == 8'h00)
		else $error("registers not cleared");
	reset_outs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset |=> general_outputs == 8'hff && !timer_running)
		else $error("outputs not high or timer running");
	tx_mark_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset ##1 1'b1 |-> serial_tx_a && serial_tx_b)
		else $error("transmit line not marking");
	no_req_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mode_r && !chain_enable_in) |=> !request_n_a_oe)
		else $error("request raised with chain blocked");
	req_cond_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!any_cond) |=> !request_n_a_oe)
		else $error("request without condition");
	chain_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mode_r && !chain_enable_in) |=> !chain_enable_out)
		else $error("chain out high while chain in low");

	rd_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!chip_sel_n && !rd_n && !master_reset) |=> host_data_lines_oe)
		else $error("read with chip select low not answered");

	rd_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(bus_rd && !ack_cycle && reg_sel == RVIC_REG_MASK) |=>
		host_data_lines_o == DW'($past(interrupt_mask_reg_r)))
		else $error("mask read data wrong");

	vec_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(hit_vec && !master_reset) |=> interrupt_vector_reg_r == $past(host_data_lines_i))
		else $error("vector write lost");

	mask_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(hit_mask && !master_reset) |=> DW'(interrupt_mask_reg_r) == $past(host_data_lines_i))
		else $error("mask write lost");

	opv_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(hit_out && !master_reset) |=>
		DW'(output_port_value_reg_r) == $past(host_data_lines_i))
		else $error("output value write lost");

	stat_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(hit_stat && !master_reset && event_set == 8'h00) |=>
		(interrupt_status_reg_r & $past(host_data_lines_i)) == 8'h00)
		else $error("status bits not cleared by write");

	stat_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!master_reset |=> (interrupt_status_reg_r & $past(event_set)) == $past(event_set))
		else $error("event did not set status");

	req_up_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req_raise && !master_reset) |=> request_n_a_oe)
		else $error("request not raised");

	reset_oe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset |=> !host_data_lines_oe)
		else $error("data driven during master reset");

	reset_req_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset |=> !request_n_a_oe)
		else $error("request during master reset");

	reset_stat_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset |=> interrupt_status_reg_r == 8'h00 && channel_status_reg_r == '0)
		else $error("status registers not cleared");

	reset_opv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		master_reset |=> output_port_value_reg_r == 8'h00)
		else $error("output value not cleared");

	chst_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> channel_status == $past(channel_status_reg_r))
		else $error("channel status output stale");

	tmr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!master_reset && !timer_restart) |=> timer_running == $past(timer_running))
		else $error("timer state changed without cause");

	tmr_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!master_reset && timer_restart) |=> timer_running)
		else $error("timer did not restart");

	gpo_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!master_reset |=> general_outputs == ~$past(output_port_value_reg_r))
		else $error("general outputs do not follow value");

	tin_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(alt_clock_sel[0] && general_inputs[RVIC_CLK_TIN]) |=> timer_ext_clock)
		else $error("timer clock not passed");

	tin_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!alt_clock_sel[0] |=> !timer_ext_clock)
		else $error("timer clock not gated");

	rxb_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(alt_clock_sel[1] && general_inputs[RVIC_CLK_RXB]) |=> rx_clock_b)
		else $error("rx clock b not passed");

	rxb_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!alt_clock_sel[1] |=> !rx_clock_b)
		else $error("rx clock b not gated");

	txb_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(alt_clock_sel[2] && general_inputs[RVIC_CLK_TXB]) |=> tx_clock_b)
		else $error("tx clock b not passed");

	txb_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!alt_clock_sel[2] |=> !tx_clock_b)
		else $error("tx clock b not gated");

	rxa_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(alt_clock_sel[3] && general_inputs[RVIC_CLK_RXA]) |=> rx_clock_a)
		else $error("rx clock a not passed");

	rxa_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!alt_clock_sel[3] |=> !rx_clock_a)
		else $error("rx clock a not gated");

	svc_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mode_r && ch_if.pending && ch_if.chain_in) ##1 1'b1 |=> !chain_enable_out)
		else $error("chain out high after request");

	ack_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!mode_r && chip_sel_n) |=> !host_data_lines_oe)
		else $error("plain mode drove data with chip select high");

	plain_ceo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!mode_r |=> chain_enable_out)
		else $error("plain mode chain out low");

	mode_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_seen_r |=> mode_r == $past(mode_r))
		else $error("bus mode changed in operation");
endmodule : rvic_top

// ==== rvic_top_test.sv ====
`timescale 1ns/100ps
module rvic_top_test;
	import rvic_pkg::*;
	logic core_clk, rst_n, mr, cei, eos, trs, cs_n, rd_n, wr_n, ack_n, oe, ro, roe, ceo;
	logic txa, txb, tr, c0, c1, c2, c3, v, req_n, cm;
	logic [7:0] ev, css, go, dout, bus, wd, d, cst;
	logic [6:0] gi;
	logic [3:0] acs;
	logic [1:0] sel;
	int n_fail = 0;
	int checked = 0;
	assign bus = oe ? dout : wd;
	assign req_n = roe ? ro : 1'b1;
	rvic_top u_rvic_top (.core_clk(core_clk), .rst_n(rst_n), .master_reset(mr),
		.chained_mode(cm), .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .reg_sel(sel),
		.host_data_lines_i(bus), .host_data_lines_o(dout), .host_data_lines_oe(oe),
		.request_n_a_ack_n(ack_n), .chain_enable_in(cei), .chain_enable_out(ceo),
		.end_of_service(eos), .event_set(ev), .general_inputs(gi), .alt_clock_sel(acs),
		.timer_restart(trs), .channel_status_set(css), .request_n_a_o(ro),
		.request_n_a_oe(roe), .general_outputs(go), .serial_tx_a(txa), .serial_tx_b(txb),
		.timer_running(tr), .timer_ext_clock(c0), .rx_clock_b(c1), .tx_clock_b(c2),
		.rx_clock_a(c3), .channel_status(cst));
	rvic_host_model u_rvic_host_model (.core_clk(core_clk), .bus(bus), .oe(oe),
		.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ack_n(ack_n), .sel(sel), .wd(wd));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step
	task automatic w(input logic [1:0] a, input logic [7:0] x);
		u_rvic_host_model.wr(a, x);
	endtask : w
	task automatic r(input logic k, input logic c, input logic [1:0] a);
		u_rvic_host_model.rd(k, c, a, d, v);
	endtask : r
	task automatic t_reset();
		w(RVIC_REG_VEC, 8'h5a);
		w(RVIC_REG_MASK, 8'h03);
		w(RVIC_REG_OUT, 8'h3c);
		css = 8'h81;
		trs = 1'b1;
		ev = 8'h04;
		step(1);
		{css, trs} = 9'h0;
		ev = 8'h00;
		step(3);
		chk("gpo", 8'hc3, go);
		chk("timer", 8'h01, {7'h0, tr});
		chk("stat", 8'h81, cst);
		r(1'b1, 1'b0, RVIC_REG_STAT);
		chk("istat", 8'h04, d);
		mr = 1'b1;
		step(2);
		mr = 1'b0;
		step(4);
		chk("stat", 8'h00, cst);
		chk("gpo", 8'hff, go);
		chk("timer", 8'h00, {7'h0, tr});
		chk("tx", 8'h03, {6'h0, txa, txb});
		r(1'b1, 1'b0, RVIC_REG_MASK);
		chk("mask", 8'h00, d);
		r(1'b1, 1'b0, RVIC_REG_VEC);
		chk("vec", RVIC_VEC_RST, d);
		r(1'b1, 1'b0, RVIC_REG_STAT);
		chk("istat", 8'h00, d);
		$display("done reset");
	endtask : t_reset
	task automatic t_cs();
		r(1'b1, 1'b1, RVIC_REG_VEC);
		chk("oe", 8'h00, {7'h0, v});
		$display("done cs");
	endtask : t_cs
	task automatic t_alt();
		int idx[4] = '{2, 6, 5, 4};
		acs = 4'hf;
		for (int i = 0; i < 4; i++) begin
			gi = 7'h1 << idx[i];
			step(3);
			chk("alt", {4'h0, 4'h8 >> i}, {4'h0, c0, c1, c2, c3});
		end
		acs = 4'h0;
		step(3);
		chk("alt", 8'h00, {4'h0, c0, c1, c2, c3});
		$display("done alt");
	endtask : t_alt
	task automatic t_request_n_a();
		w(RVIC_REG_MASK, 8'h01);
		ev = 8'h03;
		step(1);
		ev = 8'h00;
		step(3);
		chk("req", 8'h00, {7'h0, req_n});
		chk("ceo", 8'h00, {7'h0, ceo});
		r(1'b0, 1'b1, RVIC_REG_STAT);
		chk("ackv", 8'h01, {7'h0, v});
		chk("ackd", RVIC_VEC_RST, d);
		w(RVIC_REG_STAT, 8'h01);
		step(3);
		chk("req", 8'h01, {7'h0, req_n});
		chk("ceo", 8'h00, {7'h0, ceo});
		eos = 1'b1;
		step(1);
		eos = 1'b0;
		step(3);
		chk("ceo", 8'h01, {7'h0, ceo});
		$display("done request_n_a");
	endtask : t_request_n_a
	task automatic t_chain();
		cei = 1'b0;
		step(3);
		chk("ceo", 8'h00, {7'h0, ceo});
		ev = 8'h01;
		step(1);
		ev = 8'h00;
		step(3);
		chk("req", 8'h01, {7'h0, req_n});
		w(RVIC_REG_STAT, 8'h01);
		cei = 1'b1;
		step(3);
		chk("ceo", 8'h01, {7'h0, ceo});
		$display("done chain");
	endtask : t_chain
	// A mid-run reset re-samples the mode, so plain mode is reached without a second bench.
	task automatic t_plain();
		cm = 1'b0;
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		step(2);
		cei = 1'b0;
		w(RVIC_REG_MASK, 8'h01);
		ev = 8'h01;
		step(1);
		ev = 8'h00;
		step(3);
		chk("ceo", 8'h01, {7'h0, ceo});
		chk("req", 8'h00, {7'h0, req_n});
		r(1'b0, 1'b1, RVIC_REG_VEC);
		chk("oe", 8'h00, {7'h0, v});
		w(RVIC_REG_STAT, 8'h01);
		step(3);
		chk("req", 8'h01, {7'h0, req_n});
		$display("done plain");
	endtask : t_plain
	task automatic close_out();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#100000;
		n_fail++;
		close_out();
	end
	initial begin
		{rst_n, mr, eos, trs, ev, css, gi, acs} = 31'h0;
		cei = 1'b1;
		cm = 1'b1;
		repeat (16) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		step(2);
		t_reset();
		t_cs();
		t_alt();
		t_request_n_a();
		t_chain();
		t_plain();
		close_out();
	end
endmodule : rvic_top_test
